//--- uad_pkg.sv
// package of constants for the unified address decoder
package uad_pkg;
    // ------------------------------------------------------------
    // address layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 24; // 16 Mbyte space
    localparam int SEG_W = 8; // 256 segments
    localparam int PAGE_W = 2; // four pages per segment
    localparam int SEC_W = 12; // 4 Kbyte sector offset
    localparam int BLK_W = 7; // 128 byte program block
    localparam int CLUS_W = 2; // sectors per protection cluster, log2
    localparam int NFLASH = 3; // flash modules
    localparam int NCLUS = 64; // clusters for an 8-bit sector number (256 sectors / 4)
    localparam int PSR_W = 15; // program sram 32 Kbytes

    // decoded targets, one-hot
    typedef enum logic [13:0] {
        TGT_NONE = 14'h0001,
        TGT_EXT_MEM = 14'h0002,
        TGT_EXT_IO = 14'h0004,
        TGT_PERIPH = 14'h0008,
        TGT_FLASH = 14'h0010,
        TGT_PROGRAM_SRAM = 14'h0020,
        TGT_EMULATED_PROGRAM_SRAM = 14'h0040,
        TGT_DATA_SRAM = 14'h0080,
        TGT_DUAL_PORT_RAM = 14'h0100,
        TGT_SFR = 14'h0200,
        TGT_EXTENDED_FUNCTION_REGISTERS = 14'h0400,
        TGT_AUXILIARY_FUNCTION_REGISTERS = 14'h0800,
        TGT_FCTRL = 14'h1000,
        TGT_TRAP = 14'h2000
    } uad_tgt_t;

    // range bounds
    localparam logic [23:0] FCTRL_LO = 24'hffff00;
    localparam logic [23:0] TRAP_LO = 24'hf00000;
    localparam logic [23:0] EPSR_MIR_LO = 24'he88000;
    localparam logic [23:0] EPSR_LO = 24'he80000;
    localparam logic [23:0] PSR_MIR_HI = 24'he7ffff;
    localparam logic [23:0] PSR_LO = 24'he00000;
    localparam logic [23:0] PMRES_LO = 24'hcc0000;
    localparam logic [23:0] FLASH_LO = 24'hc00000;
    localparam logic [23:0] FLASH_HI = 24'hcbffff;
    localparam logic [23:0] EXT_HI_LO = 24'h400000;
    localparam logic [23:0] EXT_HI_HI = 24'hbfffff;
    localparam logic [23:0] EXTIO_LO = 24'h205800;
    localparam logic [23:0] PERI_LO = 24'h200000;
    localparam logic [23:0] EXT_MID_LO = 24'h010000;
    localparam logic [23:0] SFR_LO = 24'h00fe00;
    localparam logic [23:0] DPR_LO = 24'h00f600;
    localparam logic [23:0] DPR_HI = 24'h00fdff;
    localparam logic [23:0] DPR_BIT_LO = 24'h00fd00;
    localparam logic [23:0] DPRES_LO = 24'h00f200;
    localparam logic [23:0] EXTENDED_FUNCTION_REGISTERS_LO = 24'h00f000;
    localparam logic [23:0] EXTENDED_FUNCTION_REGISTERS_HI = 24'h00f1ff;
    localparam logic [23:0] AUXILIARY_FUNCTION_REGISTERS_LO = 24'h00e000;
    localparam logic [23:0] DSR_LO = 24'h00a000;
    localparam logic [23:0] DSR_HI = 24'h00dfff;
    localparam logic [23:0] DSRES_LO = 24'h008000;
    localparam logic [23:0] EXT_LO_HI = 24'h007fff;
    localparam logic [7:0] RES_SECTOR = 8'h3f; // top sector of module 0
    localparam logic [15:0] ZERO_DATA = 16'h0000;
endpackage

//--- uad_range.sv
// address window comparator
module uad_range #(
    parameter logic [23:0] LO = 24'h000000,
    parameter logic [23:0] HI = 24'hffffff
) (
    input wire logic [23:0] addr_i,
    output logic hit_o
);
    // inclusive window compare
    assign hit_o = (addr_i >= LO) && (addr_i <= HI);
endmodule

//--- uad_decoder.sv
// unified address decoder: fetch and data sides, flash protection
module uad_decoder (
    input wire logic clock_i,
    input wire logic rstn_i,
    // program fetch unit request
    input wire logic fetch_req_i,
    input wire logic [23:0] fetch_addr_i,
    // data transfer unit request
    input wire logic data_req_i,
    input wire logic data_we_i,
    input wire logic data_byte_i,
    input wire logic data_bit_i,
    input wire logic [23:0] data_addr_i,
    input wire logic [15:0] data_wdata_i,
    // program sram protection setup
    input wire logic psr_prot_en_i,
    input wire logic [14:0] psr_prot_size_i,
    // flash protection state
    input wire logic [63:0] flash_wprot_i,
    input wire logic flash_rprot_i,
    input wire logic pw_unlock_i,
    // system data read back from targets
    input wire logic [15:0] tgt_rdata_i,
    // fetch side outputs
    output logic fetch_vld_o,
    output logic [13:0] fetch_tgt_o,
    output logic [127:0] fetch_line_mask_o,
    output logic fetch_trap_o,
    // data side outputs, then fetch side fetch_xbus_o
    output logic data_vld_o,
    output logic [13:0] data_tgt_o,
    output logic [23:0] data_addr_o,
    output logic data_we_o,
    output logic [1:0] data_be_o,
    output logic [15:0] data_wdata_o,
    output logic [15:0] data_rdata_o,
    output logic data_trap_o,
    output logic data_bit_err_o,
    output logic data_xbus_o,
    output logic data_strict_o,
    output logic [2:0] flash_mod_o,
    output logic [7:0] flash_sector_o,
    output logic [16:0] flash_block_o,
    output logic fetch_xbus_o
);
    // ------------------------------------------------------------
    // window comparators for the data side
    // ------------------------------------------------------------
    logic h_fctrl, h_trap, h_epsr, h_epmir, h_psr, h_psmir, h_pmres, h_flash;
    logic h_exthi, h_extio, h_peri, h_extmid, h_sfr, h_dpr, h_dpres, h_extended_function_registers;
    logic h_auxiliary_function_registers, h_dsr, h_dsres, h_extlo;

    uad_range #(.LO(uad_pkg::FCTRL_LO), .HI(24'hffffff)) u_fctrl (
        .addr_i(data_addr_i), .hit_o(h_fctrl));
    uad_range #(.LO(uad_pkg::TRAP_LO), .HI(uad_pkg::FCTRL_LO - 24'h1)) u_trap (
        .addr_i(data_addr_i), .hit_o(h_trap));
    uad_range #(.LO(uad_pkg::EPSR_MIR_LO), .HI(uad_pkg::TRAP_LO - 24'h1)) u_epmir (
        .addr_i(data_addr_i), .hit_o(h_epmir));
    uad_range #(.LO(uad_pkg::EPSR_LO), .HI(uad_pkg::EPSR_MIR_LO - 24'h1)) u_epsr (
        .addr_i(data_addr_i), .hit_o(h_epsr));
    uad_range #(.LO(uad_pkg::PSR_LO), .HI(uad_pkg::PSR_MIR_HI)) u_psr (
        .addr_i(data_addr_i), .hit_o(h_psr));
    uad_range #(.LO(uad_pkg::PMRES_LO), .HI(uad_pkg::PSR_LO - 24'h1)) u_pmres (
        .addr_i(data_addr_i), .hit_o(h_pmres));
    uad_range #(.LO(uad_pkg::FLASH_LO), .HI(uad_pkg::FLASH_HI)) u_flash (
        .addr_i(data_addr_i), .hit_o(h_flash));
    uad_range #(.LO(uad_pkg::EXT_HI_LO), .HI(uad_pkg::EXT_HI_HI)) u_exthi (
        .addr_i(data_addr_i), .hit_o(h_exthi));
    uad_range #(.LO(uad_pkg::EXTIO_LO), .HI(uad_pkg::EXT_HI_LO - 24'h1)) u_extio (
        .addr_i(data_addr_i), .hit_o(h_extio));
    uad_range #(.LO(uad_pkg::PERI_LO), .HI(uad_pkg::EXTIO_LO - 24'h1)) u_peri (
        .addr_i(data_addr_i), .hit_o(h_peri));
    uad_range #(.LO(uad_pkg::EXT_MID_LO), .HI(uad_pkg::PERI_LO - 24'h1)) u_extmid (
        .addr_i(data_addr_i), .hit_o(h_extmid));
    uad_range #(.LO(uad_pkg::SFR_LO), .HI(uad_pkg::EXT_MID_LO - 24'h1)) u_sfr (
        .addr_i(data_addr_i), .hit_o(h_sfr));
    uad_range #(.LO(uad_pkg::DPR_LO), .HI(uad_pkg::DPR_HI)) u_dpr (
        .addr_i(data_addr_i), .hit_o(h_dpr));
    uad_range #(.LO(uad_pkg::DPRES_LO), .HI(uad_pkg::DPR_LO - 24'h1)) u_dpres (
        .addr_i(data_addr_i), .hit_o(h_dpres));
    uad_range #(.LO(uad_pkg::EXTENDED_FUNCTION_REGISTERS_LO), .HI(uad_pkg::EXTENDED_FUNCTION_REGISTERS_HI)) u_extended_function_registers (
        .addr_i(data_addr_i), .hit_o(h_extended_function_registers));
    uad_range #(.LO(uad_pkg::AUXILIARY_FUNCTION_REGISTERS_LO), .HI(uad_pkg::EXTENDED_FUNCTION_REGISTERS_LO - 24'h1)) u_auxiliary_function_registers (
        .addr_i(data_addr_i), .hit_o(h_auxiliary_function_registers));
    uad_range #(.LO(uad_pkg::DSR_LO), .HI(uad_pkg::DSR_HI)) u_dsr (
        .addr_i(data_addr_i), .hit_o(h_dsr));
    uad_range #(.LO(uad_pkg::DSRES_LO), .HI(uad_pkg::DSR_LO - 24'h1)) u_dsres (
        .addr_i(data_addr_i), .hit_o(h_dsres));
    uad_range #(.LO(24'h000000), .HI(uad_pkg::EXT_LO_HI)) u_extlo (
        .addr_i(data_addr_i), .hit_o(h_extlo));

    // ------------------------------------------------------------
    // registered state, one struct
    // ------------------------------------------------------------
    typedef struct packed {
        logic fvld;
        logic [13:0] ftgt;
        logic [127:0] fmask;
        logic ftrap;
        logic fxbus;
        logic dvld;
        logic [13:0] dtgt;
        logic [23:0] daddr;
        logic dwe;
        logic [1:0] dbe;
        logic [15:0] dwdata;
        logic [15:0] drdata;
        logic dtrap;
        logic dbiterr;
        logic dxbus;
        logic dstrict;
        logic [2:0] fmod;
        logic [7:0] fsec;
        logic [16:0] fblk;
    } uad_state_t;

    uad_state_t st_r, st_nxt;

    // data side target, priority irrelevant since windows are disjoint
    function automatic uad_pkg::uad_tgt_t data_target();
        uad_pkg::uad_tgt_t t;
        t = uad_pkg::TGT_NONE;
        if (h_fctrl) t = uad_pkg::TGT_FCTRL;
        else if (h_trap) t = uad_pkg::TGT_TRAP;
        else if (h_epsr || h_epmir) t = uad_pkg::TGT_EMULATED_PROGRAM_SRAM;
        else if (h_psr) t = uad_pkg::TGT_PROGRAM_SRAM;
        else if (h_pmres) t = uad_pkg::TGT_NONE;
        else if (h_flash) t = uad_pkg::TGT_FLASH;
        else if (h_exthi || h_extmid || h_extlo) t = uad_pkg::TGT_EXT_MEM;
        else if (h_extio) t = uad_pkg::TGT_EXT_IO;
        else if (h_peri) t = uad_pkg::TGT_PERIPH;
        else if (h_sfr) t = uad_pkg::TGT_SFR;
        else if (h_dpr) t = uad_pkg::TGT_DUAL_PORT_RAM;
        else if (h_extended_function_registers) t = uad_pkg::TGT_EXTENDED_FUNCTION_REGISTERS;
        else if (h_auxiliary_function_registers) t = uad_pkg::TGT_AUXILIARY_FUNCTION_REGISTERS;
        else if (h_dsr) t = uad_pkg::TGT_DATA_SRAM;
        else if (h_dpres || h_dsres) t = uad_pkg::TGT_NONE;
        return t;
    endfunction

    // fetch side decode: code comes only from program sram, emulated program sram, flash and external memory or io
    function automatic uad_pkg::uad_tgt_t fetch_target(input logic [23:0] a);
        uad_pkg::uad_tgt_t t;
        t = uad_pkg::TGT_NONE;
        if (a >= uad_pkg::FCTRL_LO) t = uad_pkg::TGT_TRAP;
        else if (a >= uad_pkg::TRAP_LO) t = uad_pkg::TGT_TRAP;
        else if (a >= uad_pkg::EPSR_LO) t = uad_pkg::TGT_EMULATED_PROGRAM_SRAM;
        else if (a >= uad_pkg::PSR_LO) t = uad_pkg::TGT_PROGRAM_SRAM;
        else if (a >= uad_pkg::PMRES_LO) t = uad_pkg::TGT_NONE;
        else if (a >= uad_pkg::FLASH_LO) t = uad_pkg::TGT_FLASH;
        else if (a >= uad_pkg::EXT_HI_LO) t = uad_pkg::TGT_EXT_MEM;
        else if (a >= uad_pkg::EXTIO_LO) t = uad_pkg::TGT_EXT_IO;
        else if (a >= uad_pkg::EXT_MID_LO && a < uad_pkg::PERI_LO) t = uad_pkg::TGT_EXT_MEM;
        else if (a <= uad_pkg::EXT_LO_HI) t = uad_pkg::TGT_EXT_MEM;
        return t;
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        uad_pkg::uad_tgt_t dt;
        uad_pkg::uad_tgt_t ft;
        logic [23:0] foff;
        logic [7:0] sec;
        logic wr_block;
        logic rd_block;
        logic bit_ok;
        dt = data_target();
        ft = fetch_target(fetch_addr_i);
        foff = data_addr_i - uad_pkg::FLASH_LO;
        sec = foff[19:12];
        wr_block = 1'b0;
        rd_block = 1'b0;
        bit_ok = 1'b0;
        st_nxt = st_r;

        // fetch side: every code fetch goes through the program fetch unit
        st_nxt.fvld = fetch_req_i;
        st_nxt.ftgt = fetch_req_i ? ft : uad_pkg::TGT_NONE;
        st_nxt.ftrap = fetch_req_i && (ft == uad_pkg::TGT_TRAP);
        // external code crosses the system bus, independent of data side
        st_nxt.fxbus = fetch_req_i && (ft == uad_pkg::TGT_EXT_MEM
            || ft == uad_pkg::TGT_EXT_IO);
        // a flash read returns a whole 128-bit line; mark the wanted word
        st_nxt.fmask = '0;
        if (fetch_req_i && ft == uad_pkg::TGT_FLASH && !flash_rprot_i) begin
            st_nxt.fmask[{fetch_addr_i[3:1], 4'h0} +: 16] = 16'hffff;
        end

        // flash addressing: module, sector, program block
        st_nxt.fmod = '0;
        if (dt == uad_pkg::TGT_FLASH) begin
            st_nxt.fmod[foff[19:18]] = 1'b1;
        end
        st_nxt.fsec = sec;
        st_nxt.fblk = foff[uad_pkg::ADDR_W-1:uad_pkg::BLK_W];

        // protection checks on data accesses
        if (dt == uad_pkg::TGT_FLASH) begin
            if (sec == uad_pkg::RES_SECTOR) begin
                wr_block = 1'b1;
                rd_block = 1'b1;
            end
            if (flash_wprot_i[sec[7:uad_pkg::CLUS_W]] && !pw_unlock_i) begin
                wr_block = 1'b1;
            end
            if (flash_rprot_i && !pw_unlock_i) begin
                rd_block = 1'b1;
            end
        end
        if (dt == uad_pkg::TGT_PROGRAM_SRAM && psr_prot_en_i
            && data_addr_i[uad_pkg::PSR_W-1:0] < psr_prot_size_i) begin
            wr_block = 1'b1;
        end

        // bit access legality
        if (dt == uad_pkg::TGT_SFR || dt == uad_pkg::TGT_EXTENDED_FUNCTION_REGISTERS) begin
            bit_ok = 1'b1;
        end else if (dt == uad_pkg::TGT_DUAL_PORT_RAM) begin
            bit_ok = data_addr_i >= uad_pkg::DPR_BIT_LO;
        end

        // data side: all transfers go through the data transfer unit
        st_nxt.dvld = data_req_i;
        st_nxt.dtgt = data_req_i ? dt : uad_pkg::TGT_NONE;
        st_nxt.daddr = data_addr_i;
        st_nxt.dwe = data_req_i && data_we_i && !wr_block
            && dt != uad_pkg::TGT_NONE && dt != uad_pkg::TGT_TRAP;
        // byte lanes: word uses both, byte picks by address bit 0
        st_nxt.dbe = data_byte_i ? (data_addr_i[0] ? 2'b10 : 2'b01) : 2'b11;
        st_nxt.dwdata = data_wdata_i;
        st_nxt.drdata = (dt == uad_pkg::TGT_NONE || rd_block)
            ? uad_pkg::ZERO_DATA : tgt_rdata_i;
        st_nxt.dtrap = data_req_i && dt == uad_pkg::TGT_TRAP;
        // bit op on a non bit-addressable target: flagged only, data_we_o not gated
        st_nxt.dbiterr = data_req_i && data_bit_i && !bit_ok;
        // operands from program memory, peripherals and off-chip resources cross over
        st_nxt.dxbus = data_req_i && (dt == uad_pkg::TGT_PROGRAM_SRAM || dt == uad_pkg::TGT_FLASH
            || dt == uad_pkg::TGT_EMULATED_PROGRAM_SRAM || dt == uad_pkg::TGT_EXT_MEM
            || dt == uad_pkg::TGT_EXT_IO || dt == uad_pkg::TGT_PERIPH);
        // external io: no reordering, no prefetch
        st_nxt.dstrict = data_req_i && dt == uad_pkg::TGT_EXT_IO;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign fetch_vld_o = st_r.fvld;
    assign fetch_tgt_o = st_r.ftgt;
    assign fetch_line_mask_o = st_r.fmask;
    assign fetch_trap_o = st_r.ftrap;
    assign fetch_xbus_o = st_r.fxbus;
    assign data_vld_o = st_r.dvld;
    assign data_tgt_o = st_r.dtgt;
    assign data_addr_o = st_r.daddr;
    assign data_we_o = st_r.dwe;
    assign data_be_o = st_r.dbe;
    assign data_wdata_o = st_r.dwdata;
    assign data_rdata_o = st_r.drdata;
    assign data_trap_o = st_r.dtrap;
    assign data_bit_err_o = st_r.dbiterr;
    assign data_xbus_o = st_r.dxbus;
    assign data_strict_o = st_r.dstrict;
    assign flash_mod_o = st_r.fmod;
    assign flash_sector_o = st_r.fsec;
    assign flash_block_o = st_r.fblk;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_io_req;
        data_req_i && h_extio;
    endsequence
    a_ext_io_strict: assert property (@(posedge clock_i) disable iff (!rstn_i)
        s_io_req |=> data_strict_o && data_tgt_o == uad_pkg::TGT_EXT_IO)
        else $error("external io access not marked strict");
    a_trap_range: assert property (@(posedge clock_i) disable iff (!rstn_i)
        data_req_i && h_trap |=> data_trap_o && !data_we_o)
        else $error("trap range did not trap");
    a_data_sram_map: assert property (@(posedge clock_i) disable iff (!rstn_i)
        data_req_i && h_dsr |=> data_tgt_o == uad_pkg::TGT_DATA_SRAM)
        else $error("data sram window misrouted");
    a_dual_port_ram_map: assert property (@(posedge clock_i) disable iff (!rstn_i)
        data_req_i && h_dpr && !data_bit_i |=> data_tgt_o == uad_pkg::TGT_DUAL_PORT_RAM
        && !data_bit_err_o)
        else $error("dual-port ram window misrouted");
    a_program_sram_prot: assert property (@(posedge clock_i) disable iff (!rstn_i)
        data_req_i && data_we_i && h_psr && psr_prot_en_i
        && data_addr_i[14:0] < psr_prot_size_i |=> !data_we_o)
        else $error("protected program sram written");
    a_reserved_zero: assert property (@(posedge clock_i) disable iff (!rstn_i)
        data_req_i && (h_pmres || h_dpres || h_dsres) |=> data_rdata_o == 16'h0000
        && !data_we_o)
        else $error("reserved range not silent");
    a_ext_mem_map: assert property (@(posedge clock_i) disable iff (!rstn_i)
        data_req_i && (h_extlo || h_extmid || h_exthi)
        |=> data_tgt_o == uad_pkg::TGT_EXT_MEM && data_xbus_o)
        else $error("external memory misrouted");
    a_byte_lane: assert property (@(posedge clock_i) disable iff (!rstn_i)
        data_byte_i |=> $onehot(data_be_o))
        else $error("byte access drove both lanes");
    a_flash_resv: assert property (@(posedge clock_i) disable iff (!rstn_i)
        data_req_i && data_we_i && data_addr_i[23:12] == 12'hc3f |=> !data_we_o)
        else $error("reserved flash sector written");
    // protection, crossing, bit and fetch checks on the remaining windows
    a_flash_rprot: assert property (@(posedge clock_i) disable iff (!rstn_i)
        data_req_i && h_flash && flash_rprot_i && !pw_unlock_i
        |=> data_rdata_o == uad_pkg::ZERO_DATA)
        else $error("read-protected flash returned data");
    a_periph_map: assert property (@(posedge clock_i) disable iff (!rstn_i)
        data_req_i && h_peri |=> data_tgt_o == uad_pkg::TGT_PERIPH && data_xbus_o)
        else $error("peripheral registers misrouted");
    a_program_sram_map: assert property (@(posedge clock_i) disable iff (!rstn_i)
        data_req_i && h_psr |=> data_tgt_o == uad_pkg::TGT_PROGRAM_SRAM && data_xbus_o)
        else $error("program sram or mirror misrouted");
    a_bit_regs: assert property (@(posedge clock_i) disable iff (!rstn_i)
        data_req_i && data_bit_i && (h_sfr || h_extended_function_registers) |=> !data_bit_err_o)
        else $error("bit op on register area refused");
    a_fetch_trap: assert property (@(posedge clock_i) disable iff (!rstn_i)
        fetch_req_i && fetch_addr_i >= uad_pkg::TRAP_LO
        |=> fetch_trap_o && fetch_tgt_o == uad_pkg::TGT_TRAP)
        else $error("fetch from trap range did not trap");
    a_flash_line: assert property (@(posedge clock_i) disable iff (!rstn_i)
        fetch_req_i && fetch_addr_i >= uad_pkg::FLASH_LO && fetch_addr_i <= uad_pkg::FLASH_HI
        && !flash_rprot_i |=> $countones(fetch_line_mask_o) == 16)
        else $error("flash fetch line mask not one word");
endmodule

//--- uad_core_model.sv
// processor core model: fetch and data request ports facing the decoder
module uad_core_model (
    input wire logic clock_i,
    output logic fetch_req_o,
    output logic [23:0] fetch_addr_o,
    output logic data_req_o,
    output logic data_we_o,
    output logic data_byte_o,
    output logic data_bit_o,
    output logic [23:0] data_addr_o,
    output logic [15:0] data_wdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // idle ports at time zero
    // ----------------------------------------
    initial begin
        fetch_req_o = 1'b0;
        fetch_addr_o = 24'h000000;
        data_req_o = 1'b0;
        {data_we_o, data_byte_o, data_bit_o} = 3'h0;
        data_addr_o = 24'h000000;
        data_wdata_o = 16'h0000;
    end
    // ----------------------------------------
    // one request cycle on both ports, just after the edge
    // ----------------------------------------
    // callers pass zero data for writes into register areas
    task automatic issue(input logic f, input logic [23:0] fa, input logic d,
                         input logic [2:0] wbb, input logic [23:0] da, input logic [15:0] wd);
        @(posedge clock_i);
        #1;
        fetch_req_o = f;
        fetch_addr_o = f ? fa : ~fetch_addr_o; // released lines toggle
        data_req_o = d;
        {data_we_o, data_byte_o, data_bit_o} = d ? wbb : ~{data_we_o, data_byte_o, data_bit_o};
        data_addr_o = d ? da : ~data_addr_o;
        data_wdata_o = d ? wd : ~data_wdata_o;
    endtask
endmodule

//--- unified_address_decoder_tb.sv
// self-checking testbench for the unified address decoder
module unified_address_decoder_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // signals, named as the decoder ports
    // ----------------------------------------
    logic clock_i, rstn_i, fetch_req_i, data_req_i, data_we_i, data_byte_i, data_bit_i;
    logic [23:0] fetch_addr_i, data_addr_i, data_addr_o;
    logic [15:0] data_wdata_i, tgt_rdata_i, data_wdata_o, data_rdata_o;
    logic psr_prot_en_i, flash_rprot_i, pw_unlock_i;
    logic [14:0] psr_prot_size_i;
    logic [63:0] flash_wprot_i;
    logic fetch_vld_o, fetch_trap_o, fetch_xbus_o, data_vld_o, data_we_o, data_trap_o;
    logic data_bit_err_o, data_xbus_o, data_strict_o;
    logic [13:0] fetch_tgt_o, data_tgt_o;
    logic [127:0] fetch_line_mask_o;
    logic [1:0] data_be_o;
    logic [2:0] flash_mod_o;
    logic [7:0] flash_sector_o;
    logic [16:0] flash_block_o;
    int n_fail;
    int total_checks;
    // decode table: address, data target bit, fetch target bit (15 = not checked)
    localparam logic [23:0] DA [25] = '{24'h000000, 24'h007fff, 24'h008000, 24'h00a000,
        24'h00dfff, 24'h00e000, 24'h00f000, 24'h00f200, 24'h00f600, 24'h00fdff, 24'h00fe00,
        24'h010000, 24'h200000, 24'h2057ff, 24'h205800, 24'h400000, 24'hc00000, 24'hcbffff,
        24'hcc0000, 24'he00000, 24'he7ffff, 24'he80000, 24'hf00000, 24'hfffeff, 24'hffff00};
    localparam int DT [25] = '{1, 1, 0, 7, 7, 11, 10, 0, 8, 8, 9, 1, 3, 3, 2, 1, 4, 4, 0, 5, 5,
        6, 13, 13, 12};
    localparam int FT [25] = '{15, 15, 0, 0, 15, 15, 0, 15, 0, 15, 0, 15, 0, 15, 2, 1, 4,
        15, 0, 5, 15, 6, 13, 15, 13};
    uad_decoder i_dut (.clock_i, .rstn_i, .fetch_req_i, .fetch_addr_i, .data_req_i, .data_we_i,
        .data_byte_i, .data_bit_i, .data_addr_i, .data_wdata_i, .psr_prot_en_i, .psr_prot_size_i,
        .flash_wprot_i, .flash_rprot_i, .pw_unlock_i, .tgt_rdata_i, .fetch_vld_o, .fetch_tgt_o,
        .fetch_line_mask_o, .fetch_trap_o, .data_vld_o, .data_tgt_o, .data_addr_o, .data_we_o,
        .data_be_o, .data_wdata_o, .data_rdata_o, .data_trap_o, .data_bit_err_o, .data_xbus_o,
        .data_strict_o, .flash_mod_o, .flash_sector_o, .flash_block_o, .fetch_xbus_o);
    uad_core_model i_core (.clock_i, .fetch_req_o(fetch_req_i), .fetch_addr_o(fetch_addr_i),
        .data_req_o(data_req_i), .data_we_o(data_we_i), .data_byte_o(data_byte_i),
        .data_bit_o(data_bit_i), .data_addr_o(data_addr_i), .data_wdata_o(data_wdata_i));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // one data request, then idle so its answer is settled on return
    task automatic dop(input logic [2:0] wbb, input logic [23:0] a, input logic [15:0] wd);
        i_core.issue(1'b0, 24'h0, 1'b1, wbb, a, wd);
        i_core.issue(1'b0, 24'h0, 1'b0, 3'h0, 24'h0, 16'h0);
    endtask
    task automatic wchk(input logic [23:0] a, input logic exp);
        dop(3'b100, a, 16'h0000);
        check("write qualified", data_we_o, exp);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // back-to-back reads over every area, fetch port busy in the cycles whose fetch target is checked
    task automatic t_decode;
        int j;
        for (int i = 0; i <= 25; i++) begin
            if (i < 25) begin
                i_core.issue(FT[i] != 15, DA[i], 1'b1, 3'b000, DA[i], 16'h0);
            end else begin
                i_core.issue(1'b0, 24'h0, 1'b0, 3'h0, 24'h0, 16'h0);
            end
            if (i > 0) begin
                j = i - 1;
                check("data target", data_tgt_o, 14'h0001 << DT[j]);
                check("data valid", data_vld_o, 1'b1);
                check("data crossing", data_xbus_o, DT[j] >= 1 && DT[j] <= 6);
                check("fetch valid", fetch_vld_o, FT[j] != 15);
                check("data address", data_addr_o, DA[j]);
                check("word lanes", data_be_o, 2'b11);
                check("data trap", data_trap_o, DT[j] == 13);
                check("strict order", data_strict_o, DT[j] == 2);
                if (DT[j] != 13) begin
                    check("read data", data_rdata_o, (DT[j] == 0) ? 16'h0 : 16'h5a5a);
                end
                if (FT[j] != 15) begin
                    check("fetch target", fetch_tgt_o, 14'h0001 << FT[j]);
                    check("fetch trap", fetch_trap_o, FT[j] == 13);
                    check("fetch crossing", fetch_xbus_o, FT[j] == 1 || FT[j] == 2);
                end
            end
        end
    endtask
    // word and byte lanes, write pass-through, reserved write dropped
    task automatic t_sizes;
        dop(3'b100, 24'h00a010, 16'h1234);
        check("word lanes", data_be_o, 2'b11);
        check("write data", data_wdata_o, 16'h1234);
        check("write qualified", data_we_o, 1'b1);
        dop(3'b110, 24'h00a010, 16'h0012);
        check("even byte", data_be_o, 2'b01);
        dop(3'b110, 24'h00a011, 16'h0034);
        check("odd byte", data_be_o, 2'b10);
        wchk(24'h008000, 1'b0);
    endtask
    // protected window of program sram, also through its mirror
    task automatic t_program_sram;
        psr_prot_en_i = 1'b1;
        psr_prot_size_i = 15'h0100;
        wchk(24'he000fe, 1'b0);
        wchk(24'he00100, 1'b1);
        wchk(24'he080fe, 1'b0);
        psr_prot_en_i = 1'b0;
        wchk(24'he000fe, 1'b1);
    endtask
    // single-bit operations only in bit-addressable areas
    task automatic t_bit;
        logic [23:0] ba [7] = '{24'h00fd00, 24'h00fdff, 24'h00fcff, 24'h00fe00, 24'h00f000,
            24'h00f1ff, 24'h00a000};
        logic be [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 7; i++) begin
            dop(3'b001, ba[i], 16'h0);
            check("bit error", data_bit_err_o, be[i]);
        end
    endtask
    // flash modules, sectors, protection and password unlock
    task automatic t_flash;
        i_core.issue(1'b1, 24'hc00006, 1'b1, 3'b000, 24'hc41234, 16'h0);
        i_core.issue(1'b0, 24'h0, 1'b0, 3'h0, 24'h0, 16'h0);
        check("flash module", flash_mod_o, 3'b010);
        check("flash sector", flash_sector_o, 8'h41);
        check("program block", flash_block_o, 17'h00824);
        check("line mask", fetch_line_mask_o, 128'hffff << 48);
        flash_wprot_i = 64'h1 << 16;
        wchk(24'hc41234, 1'b0);
        wchk(24'hc43ff0, 1'b0);
        wchk(24'hc50000, 1'b1);
        pw_unlock_i = 1'b1;
        wchk(24'hc41234, 1'b1);
        wchk(24'hc3f010, 1'b0);
        flash_rprot_i = 1'b1;
        dop(3'b000, 24'hc00010, 16'h0);
        check("unlocked read", data_rdata_o, 16'h5a5a);
        pw_unlock_i = 1'b0;
        dop(3'b000, 24'hc00010, 16'h0);
        check("protected read", data_rdata_o, 16'h0000);
        flash_rprot_i = 1'b0;
        flash_wprot_i = 64'h0;
        dop(3'b000, 24'hc3f000, 16'h0);
        check("reserved sector", data_rdata_o, 16'h0000);
    endtask
    // ----------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end
    initial begin
        rstn_i = 1'b0;
        psr_prot_en_i = 1'b0;
        psr_prot_size_i = 15'h0000;
        flash_wprot_i = 64'h0;
        flash_rprot_i = 1'b0;
        pw_unlock_i = 1'b0;
        tgt_rdata_i = 16'h5a5a;
        repeat (6) @(posedge clock_i);
        #1;
        rstn_i = 1'b1;
        t_decode();
        t_sizes();
        t_program_sram();
        t_bit();
        t_flash();
        give_verdict();
    end
endmodule
